// [verilog/mbslv_cfg.svh]
// Constants for the serial register-access slave frame handler
// What this block does
// - Register reads use function 3; answer is data or an exception frame.
// - At most 123 registers are returned in one read response.
// - Read counts above 123 return the first 123 registers, no exception.
// - Read reply: address, 3, byte count twice registers, data high first, CRC.
// - Failed read reply: address, 131, exception 2, CRC low then high.
// - Writes use function 6 and change exactly one 16-bit register.
// - Successful write reply echoes the query byte for byte, CRC included.
// - Failed write reply: function 134, exception 2 bad address, 10 protected.
// - Check value is 16 bits, preset to all ones before the first byte.
// - Each byte is first XORed into the check value's low byte.
// - Then eight right shifts, XOR with A001h when a one falls out.
// - Check value is appended low byte first, then high byte.
// - Check matches reference frames ending 45 CC and 89 D2.
// - Characters carry eight data bits, no parity, one stop bit.
// - Act only on queries matching own slave address, valid range 1 to 240.
// - Link rate configurable from 2400 to 115200 baud, same on all nodes.
`ifndef MBSLV_CFG_SVH
`define MBSLV_CFG_SVH

`define MBSLV_CLK_HZ        250000000
`define MBSLV_FN_READ       8'h03
`define MBSLV_FN_WRITE      8'h06
`define MBSLV_EXC_FLAG      8'h80
`define MBSLV_EXC_ADDR      8'h02
`define MBSLV_EXC_WPROT     8'h0A
`define MBSLV_MAX_REGS      8'h7B
`define MBSLV_CRC_INIT      16'hFFFF
`define MBSLV_CRC_POLY      16'hA001
`define MBSLV_ADDR_MIN      8'h01
`define MBSLV_ADDR_MAX      8'hF0
`define MBSLV_QUERY_LEN     4'h8
`define MBSLV_CHAR_BITS     10
`define MBSLV_IDLE_HALFCH   7

`endif

// [verilog/mbslv_pkg.sv]
// Types shared by the slave frame handler
package mbslv_pkg;
   typedef enum logic [2:0] {
      MBSLV_IDLE = 3'b000,
      MBSLV_RECV = 3'b001,
      MBSLV_DROP = 3'b010,
      MBSLV_EXEC = 3'b011,
      MBSLV_WAIT = 3'b100,
      MBSLV_SEND = 3'b101,
      MBSLV_CRCL = 3'b110,
      MBSLV_CRCH = 3'b111
   } mbslv_state_e;

   typedef enum logic [1:0] {
      MBSLV_RSP_READ = 2'b00,
      MBSLV_RSP_ECHO = 2'b01,
      MBSLV_RSP_EXC  = 2'b10
   } mbslv_rsp_e;
endpackage

// [verilog/mbslv_crc.sv]
// Byte-wide CRC-16 engine for the slave frame handler
`timescale 1ns/100ps
`default_nettype none
`include "mbslv_cfg.svh"
module mbslv_crc (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        clear,
   input  wire logic        byte_vld,
   input  wire logic [7:0]  byte_in,
   output logic      [15:0] crc
);
   import mbslv_pkg::*;
   logic [15:0] next_crc;

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] v;
      v = {c[15:8], c[7:0] ^ b};
      for (int i = 0; i < 8; i++) begin
         v = v[0] ? ((v >> 1) ^ `MBSLV_CRC_POLY) : (v >> 1);
      end
      return v;
   endfunction

   always_comb begin
      next_crc = crc;
      if (clear) begin
         next_crc = `MBSLV_CRC_INIT;
      end else if (byte_vld) begin
         next_crc = crc_step(crc, byte_in);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         crc <= `MBSLV_CRC_INIT;
      end else begin
         crc <= next_crc;
      end
   end
endmodule
`default_nettype wire

// [verilog/mbslv_gap.sv]
// Bus idle timer that marks frame ends
`timescale 1ns/100ps
`default_nettype none
`include "mbslv_cfg.svh"
module mbslv_gap #(
   parameter int BAUD = 9600
) (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic activity,
   output logic      frame_end
);
   import mbslv_pkg::*;
   // Idle limit in clock cycles: 3.5 characters, rounded up
   localparam int BIT_CYC = `MBSLV_CLK_HZ / BAUD;
   localparam int GAP_CYC = (BIT_CYC * `MBSLV_CHAR_BITS * `MBSLV_IDLE_HALFCH + 1) / 2;
   localparam int CW = $clog2(GAP_CYC + 2);
   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;
   logic          armed;
   logic          next_armed;

   always_comb begin
      next_cnt   = cnt;
      next_armed = armed;
      frame_end  = 1'b0;
      if (activity) begin
         next_cnt   = '0;
         next_armed = 1'b1;
      end else if (armed) begin
         if (cnt == CW'(GAP_CYC - 1)) begin
            frame_end  = 1'b1;
            next_armed = 1'b0;
         end else begin
            next_cnt = cnt + CW'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt   <= '0;
         armed <= 1'b0;
      end else begin
         cnt   <= next_cnt;
         armed <= next_armed;
      end
   end
endmodule
`default_nettype wire

// [verilog/mbslv_top.sv]
// Serial register-access slave: query decode, register access, reply build
`timescale 1ns/100ps
`default_nettype none
`include "mbslv_cfg.svh"
module mbslv_top #(
   parameter int BAUD = 9600
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic [7:0]  slave_addr,
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_data,
   input  wire logic        rx_busy,
   output logic             tx_valid,
   output logic      [7:0]  tx_data,
   input  wire logic        tx_ready,
   input  wire logic        tx_busy,
   output logic             rd_req,
   output logic      [15:0] rd_addr,
   input  wire logic        rd_ack,
   input  wire logic        rd_err,
   input  wire logic [15:0] rd_data,
   output logic             wr_req,
   output logic      [15:0] wr_addr,
   output logic      [15:0] wr_data,
   input  wire logic        wr_ack,
   input  wire logic        wr_err_addr,
   input  wire logic        wr_err_prot
);
   import mbslv_pkg::*;
   // Character framing (8N1) and baud timing live in the attached UART;
   // BAUD only sizes the idle gap and should be 2400..115200.

   mbslv_state_e state, next_state;
   mbslv_rsp_e   rsp, next_rsp;
   logic [7:0]   qbuf [0:7];
   logic [7:0]   next_qbuf [0:7];
   logic [3:0]   qcnt, next_qcnt;
   logic [6:0]   nregs, next_nregs;
   logic [6:0]   ridx, next_ridx;
   logic [15:0]  rword, next_rword;
   logic [7:0]   pos, next_pos;
   logic [7:0]   excode, next_excode;
   logic         hi, next_hi;
   logic [7:0]   next_tx_data;
   logic         next_tx_valid;
   logic         next_rd_req, next_wr_req;
   logic [15:0]  next_rd_addr, next_wr_addr, next_wr_data;
   logic         crc_clr, crc_vld;
   logic [7:0]   crc_byte;
   logic [15:0]  crc;
   logic         frame_end;
   logic [15:0]  q_start, q_cnt;
   logic         addr_ok;

   assign q_start = {qbuf[2], qbuf[3]};
   assign q_cnt   = {qbuf[4], qbuf[5]};
   assign addr_ok = (slave_addr >= `MBSLV_ADDR_MIN) && (slave_addr <= `MBSLV_ADDR_MAX);

   mbslv_crc u_crc (
      .clk      (clk),
      .nrst     (nrst),
      .clear    (crc_clr),
      .byte_vld (crc_vld),
      .byte_in  (crc_byte),
      .crc      (crc)
   );

   mbslv_gap #(.BAUD(BAUD)) u_gap (
      .clk       (clk),
      .nrst      (nrst),
      .activity  (rx_valid | rx_busy),
      .frame_end (frame_end)
   );

   always_comb begin
      next_state   = state;
      next_rsp     = rsp;
      next_qbuf    = qbuf;
      next_qcnt    = qcnt;
      next_nregs   = nregs;
      next_ridx    = ridx;
      next_rword   = rword;
      next_pos     = pos;
      next_excode  = excode;
      next_hi      = hi;
      next_tx_data = tx_data;
      next_tx_valid = tx_valid;
      next_rd_req  = rd_req;
      next_rd_addr = rd_addr;
      next_wr_req  = wr_req;
      next_wr_addr = wr_addr;
      next_wr_data = wr_data;
      crc_clr      = 1'b0;
      crc_vld      = 1'b0;
      crc_byte     = rx_data;
      case (state)
         MBSLV_IDLE: begin
            crc_clr = 1'b1;
            if (rx_valid) begin
               // Only our own address starts collection; others are ignored wholesale
               if (addr_ok && rx_data == slave_addr) begin
                  next_qbuf[0] = rx_data;
                  next_qcnt    = 4'h1;
                  next_state   = MBSLV_RECV;
                  crc_clr      = 1'b0;
                  crc_vld      = 1'b1;
               end else begin
                  next_state = MBSLV_DROP;
               end
            end
         end
         MBSLV_DROP: begin
            if (frame_end) begin
               next_state = MBSLV_IDLE;
            end
         end
         MBSLV_RECV: begin
            if (rx_valid) begin
               if (qcnt < `MBSLV_QUERY_LEN) begin
                  next_qbuf[qcnt[2:0]] = rx_data;
                  next_qcnt = qcnt + 4'h1;
                  crc_vld   = 1'b1;
               end else begin
                  next_state = MBSLV_DROP;
               end
            end else if (frame_end) begin
               // Running CRC over all eight bytes leaves zero when the check is good
               if (qcnt == `MBSLV_QUERY_LEN && crc == 16'h0000 &&
                   (qbuf[1] == `MBSLV_FN_READ || qbuf[1] == `MBSLV_FN_WRITE)) begin
                  next_state = MBSLV_EXEC;
               end else begin
                  next_state = MBSLV_IDLE;
               end
            end
         end
         MBSLV_EXEC: begin
            next_pos = 8'h00;
            next_hi  = 1'b1;
            next_ridx = 7'h00;
            if (qbuf[1] == `MBSLV_FN_READ) begin
               // Oversized counts are clipped, not refused
               if (q_cnt > 16'(`MBSLV_MAX_REGS)) begin
                  next_nregs = 7'(`MBSLV_MAX_REGS);
               end else begin
                  next_nregs = q_cnt[6:0];
               end
               next_rsp = MBSLV_RSP_READ;
               if (q_cnt == 16'h0000) begin
                  next_rsp    = MBSLV_RSP_EXC;
                  next_excode = `MBSLV_EXC_ADDR;
                  next_state  = MBSLV_SEND;
               end else begin
                  next_rd_req  = 1'b1;
                  next_rd_addr = q_start;
                  next_state   = MBSLV_WAIT;
               end
            end else begin
               next_wr_req  = 1'b1;
               next_wr_addr = q_start;
               next_wr_data = q_cnt;
               next_rsp     = MBSLV_RSP_ECHO;
               next_state   = MBSLV_WAIT;
            end
         end
         MBSLV_WAIT: begin
            crc_byte = tx_data;
            if (tx_valid && tx_ready) begin
               next_tx_valid = 1'b0;
               crc_vld       = 1'b1;
            end
            if (rsp == MBSLV_RSP_READ && rd_req && (rd_ack || rd_err)) begin
               next_rd_req = 1'b0;
               if (rd_err) begin
                  next_rsp    = MBSLV_RSP_EXC;
                  next_excode = `MBSLV_EXC_ADDR;
                  next_pos    = 8'h00;
               end else begin
                  next_rword   = rd_data;
                  next_ridx    = ridx + 7'h01;
                  next_rd_addr = rd_addr + 16'h0001;
               end
               // First word fetched before header; later words on demand
               next_state = MBSLV_SEND;
               next_hi    = 1'b1;
            end else if (wr_req && (wr_ack || wr_err_addr || wr_err_prot)) begin
               next_wr_req = 1'b0;
               if (wr_err_addr || wr_err_prot) begin
                  next_rsp    = MBSLV_RSP_EXC;
                  next_excode = wr_err_addr ? `MBSLV_EXC_ADDR : `MBSLV_EXC_WPROT;
               end
               next_state = MBSLV_SEND;
            end
         end
         MBSLV_SEND: begin
            crc_byte = tx_data;
            if (tx_valid) begin
               if (tx_ready) begin
                  next_tx_valid = 1'b0;
                  crc_vld       = 1'b1;
               end
            end else if (rsp == MBSLV_RSP_ECHO) begin
               next_tx_data  = qbuf[pos[2:0]];
               next_tx_valid = 1'b1;
               next_pos      = pos + 8'h01;
               if (pos == 8'h07) begin
                  next_state = MBSLV_IDLE;
               end
            end else if (pos == 8'h00) begin
               next_tx_data  = qbuf[0];
               next_tx_valid = 1'b1;
               next_pos      = 8'h01;
               crc_clr       = 1'b1;
            end else if (pos == 8'h01) begin
               next_tx_data  = (rsp == MBSLV_RSP_EXC) ? (qbuf[1] | `MBSLV_EXC_FLAG) : qbuf[1];
               next_tx_valid = 1'b1;
               next_pos      = 8'h02;
            end else if (pos == 8'h02) begin
               next_tx_data  = (rsp == MBSLV_RSP_EXC) ? excode : {nregs, 1'b0};
               next_tx_valid = 1'b1;
               next_pos      = 8'h03;
               if (rsp == MBSLV_RSP_EXC) begin
                  next_state = MBSLV_CRCL;
               end
            end else begin
               next_tx_data  = hi ? rword[15:8] : rword[7:0];
               next_tx_valid = 1'b1;
               next_hi       = ~hi;
               if (!hi) begin
                  if (ridx == nregs) begin
                     next_state = MBSLV_CRCL;
                  end else begin
                     next_rd_req = 1'b1;
                     next_state  = MBSLV_WAIT;
                  end
               end
            end
         end
         MBSLV_CRCL: begin
            crc_byte = tx_data;
            if (tx_valid) begin
               if (tx_ready) begin
                  next_tx_valid = 1'b0;
                  crc_vld       = 1'b1;
               end
            end else begin
               next_tx_data  = crc[7:0];
               next_tx_valid = 1'b1;
               next_state    = MBSLV_CRCH;
            end
         end
         MBSLV_CRCH: begin
            if (tx_valid) begin
               if (tx_ready) begin
                  next_tx_valid = 1'b0;
               end
            end else if (pos != 8'hFF) begin
               next_tx_data  = crc[15:8];
               next_tx_valid = 1'b1;
               next_pos      = 8'hFF;
            end else if (!tx_busy) begin
               next_state = MBSLV_IDLE;
            end
         end
         default: begin
            next_state = MBSLV_IDLE;
         end
      endcase
      // Echo path must also wait for the last byte to be accepted
      if (state == MBSLV_SEND && rsp == MBSLV_RSP_ECHO && !tx_valid && pos == 8'h07) begin
         next_state = MBSLV_CRCH;
         next_pos   = 8'hFF;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state    <= MBSLV_IDLE;
         rsp      <= MBSLV_RSP_READ;
         qcnt     <= 4'h0;
         nregs    <= 7'h00;
         ridx     <= 7'h00;
         rword    <= 16'h0000;
         pos      <= 8'h00;
         excode   <= 8'h00;
         hi       <= 1'b1;
         tx_data  <= 8'h00;
         tx_valid <= 1'b0;
         rd_req   <= 1'b0;
         rd_addr  <= 16'h0000;
         wr_req   <= 1'b0;
         wr_addr  <= 16'h0000;
         wr_data  <= 16'h0000;
         for (int i = 0; i < 8; i++) begin
            qbuf[i] <= 8'h00;
         end
      end else begin
         state    <= next_state;
         rsp      <= next_rsp;
         qcnt     <= next_qcnt;
         nregs    <= next_nregs;
         ridx     <= next_ridx;
         rword    <= next_rword;
         pos      <= next_pos;
         excode   <= next_excode;
         hi       <= next_hi;
         tx_data  <= next_tx_data;
         tx_valid <= next_tx_valid;
         rd_req   <= next_rd_req;
         rd_addr  <= next_rd_addr;
         wr_req   <= next_wr_req;
         wr_addr  <= next_wr_addr;
         wr_data  <= next_wr_data;
         for (int i = 0; i < 8; i++) begin
            qbuf[i] <= next_qbuf[i];
         end
      end
   end
endmodule
`default_nettype wire

// [tb/mbslv_checker.sv]
// Port-level assertions for the slave frame handler
`timescale 1ns/100ps
`default_nettype none
module mbslv_checker #(
   parameter int BAUD = 9600
) (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic [7:0]  slave_addr,
   input wire logic        rx_valid,
   input wire logic [7:0]  rx_data,
   input wire logic        rx_busy,
   input wire logic        tx_valid,
   input wire logic [7:0]  tx_data,
   input wire logic        tx_ready,
   input wire logic        tx_busy,
   input wire logic        rd_req,
   input wire logic [15:0] rd_addr,
   input wire logic        rd_ack,
   input wire logic        rd_err,
   input wire logic [15:0] rd_data,
   input wire logic        wr_req,
   input wire logic [15:0] wr_addr,
   input wire logic [15:0] wr_data,
   input wire logic        wr_ack,
   input wire logic        wr_err_addr,
   input wire logic        wr_err_prot
);
   logic [7:0] tx_cnt;
   logic [7:0] ack_cnt;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   // Both counts restart with each received byte, so they span one reply
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_cnt  <= 8'h00;
         ack_cnt <= 8'h00;
      end else if (rx_valid) begin
         tx_cnt  <= 8'h00;
         ack_cnt <= 8'h00;
      end else begin
         tx_cnt  <= tx_cnt + 8'(tx_valid && tx_ready);
         ack_cnt <= ack_cnt + 8'(rd_ack);
      end
   end

   a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("tx byte dropped or changed before accept");
   a_rd_hold: assert property (rd_req && !rd_ack && !rd_err |=> rd_req && $stable(rd_addr))
      else $error("read request not held");
   a_rd_release: assert property (rd_req && (rd_ack || rd_err) |=> !rd_req)
      else $error("read request kept after answer");
   a_wr_hold: assert property (wr_req && !wr_ack && !wr_err_addr && !wr_err_prot
      |=> wr_req && $stable({wr_addr, wr_data}))
      else $error("write request not held");
   a_wr_single: assert property (wr_req && (wr_ack || wr_err_addr || wr_err_prot)
      |=> !wr_req [*8])
      else $error("second write after one query");
   a_no_mix: assert property (!(rd_req && wr_req) && !(wr_req && tx_valid))
      else $error("write overlaps read or reply");
   a_bad_self: assert property ((slave_addr == 8'h00 || slave_addr > 8'hF0)
      |-> !tx_valid && !rd_req && !wr_req)
      else $error("activity with invalid own address");
   a_reply_addr: assert property (tx_valid && tx_cnt == 8'h00 |-> tx_data == slave_addr)
      else $error("reply does not start with own address");
   a_reply_fn: assert property (tx_valid && tx_cnt == 8'h01
      |-> tx_data inside {8'h03, 8'h06, 8'h83, 8'h86})
      else $error("reply function byte wrong");
   a_max_regs: assert property (ack_cnt <= 8'h7B)
      else $error("more than 123 words fetched");
endmodule

bind mbslv_top mbslv_checker #(.BAUD(BAUD)) mbslv_checker_inst (
   .clk(clk), .nrst(nrst), .slave_addr(slave_addr), .rx_valid(rx_valid),
   .rx_data(rx_data), .rx_busy(rx_busy), .tx_valid(tx_valid), .tx_data(tx_data),
   .tx_ready(tx_ready), .tx_busy(tx_busy), .rd_req(rd_req), .rd_addr(rd_addr),
   .rd_ack(rd_ack), .rd_err(rd_err), .rd_data(rd_data), .wr_req(wr_req),
   .wr_addr(wr_addr), .wr_data(wr_data), .wr_ack(wr_ack),
   .wr_err_addr(wr_err_addr), .wr_err_prot(wr_err_prot));
`default_nettype wire

// [tb/mbslv_master.sv]
// Serial master model with its byte-level line interface
`timescale 1ns/100ps
`default_nettype none
module mbslv_master (
   input  wire logic       clk,
   output logic            rx_valid,
   output logic      [7:0] rx_data,
   output logic            rx_busy,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output logic            tx_ready,
   output logic            tx_busy
);
   logic [7:0] rsp_q[$];
   logic       slow = 1'b0;

   initial begin
      {rx_valid, rx_busy, tx_ready, tx_busy} = 4'h0;
      rx_data = 8'h00;
   end

   // Busy while the character shifts, then a one-cycle strobe; data inverted when idle
   task automatic send_byte(input logic [7:0] b);
      @(posedge clk);
      #1;
      rx_busy = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      rx_busy = 1'b0;
      rx_valid = 1'b1;
      rx_data = b;
      @(posedge clk);
      #1;
      rx_valid = 1'b0;
      rx_data = ~b;
   endtask

   // Slow mode lets each offered byte wait before it is taken
   always begin
      @(posedge clk);
      if (tx_valid === 1'b1) begin
         if (slow) repeat (3) @(posedge clk);
         #1;
         tx_ready = 1'b1;
         @(posedge clk);
         rsp_q.push_back(tx_data);
         #1;
         tx_ready = 1'b0;
         tx_busy = 1'b1;
         repeat (4) @(posedge clk);
         #1;
         tx_busy = 1'b0;
      end
   end
endmodule
`default_nettype wire

// [tb/mbslv_top_tb.sv]
// Self-checking bench for the slave frame handler
`timescale 1ns/100ps
`default_nettype none
module mbslv_top_tb;
   typedef logic [7:0] mbslv_bq_t[$];
   localparam int BAUD = 5000000;
   localparam int GAP  = 35 * (250000000 / BAUD);
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic [7:0]  slave_addr = 8'h01;
   logic        rx_valid, rx_busy, tx_valid, tx_ready, tx_busy, rd_req, wr_req;
   logic [7:0]  rx_data, tx_data;
   logic        rd_ack = 1'b0, rd_err = 1'b0;
   logic [15:0] rd_addr, wr_addr, wr_data, wr_seen_addr, wr_seen_data;
   logic [15:0] rd_data = 16'h0000;
   logic        wr_ack = 1'b0, wr_err_addr = 1'b0, wr_err_prot = 1'b0;
   logic [15:0] lfsr = 16'h9E3A;
   int          miscompares = 0;
   int          cmp_count = 0;
   int          acc_count = 0;

   always #2 clk = ~clk;

   mbslv_top #(.BAUD(BAUD)) mbslv_top_inst (
      .clk(clk), .nrst(nrst), .slave_addr(slave_addr), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_busy(rx_busy), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_ready(tx_ready), .tx_busy(tx_busy), .rd_req(rd_req), .rd_addr(rd_addr),
      .rd_ack(rd_ack), .rd_err(rd_err), .rd_data(rd_data), .wr_req(wr_req),
      .wr_addr(wr_addr), .wr_data(wr_data), .wr_ack(wr_ack),
      .wr_err_addr(wr_err_addr), .wr_err_prot(wr_err_prot));
   mbslv_master mbslv_master_inst (
      .clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_busy(rx_busy),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .tx_busy(tx_busy));

   function automatic logic [15:0] lfsr_next();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction

   function automatic logic [15:0] reg_val(input logic [15:0] a);
      return a ^ 16'h5A3C;
   endfunction

   function automatic logic [15:0] crc16(input mbslv_bq_t b);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (b[i]) begin
         c[7:0] = c[7:0] ^ b[i];
         repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
      end
      return c;
   endfunction

   function automatic void add_crc(ref mbslv_bq_t q);
      logic [15:0] c;
      c = crc16(q);
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
   endfunction

   function automatic mbslv_bq_t mkq(input logic [7:0] sl, fn, input logic [15:0] a, d);
      mbslv_bq_t q;
      q = {sl, fn, a[15:8], a[7:0], d[15:8], d[7:0]};
      add_crc(q);
      return q;
   endfunction

   // Expected reply; top pages fail: F on read, E unmapped and D protected on write
   function automatic mbslv_bq_t reply(input mbslv_bq_t q);
      mbslv_bq_t   r;
      logic [15:0] a, n, v;
      if (q.size() != 8 || crc16(q) != 16'h0000 || q[0] != slave_addr) return r;
      if (slave_addr == 8'h00 || slave_addr > 8'hF0 || !(q[1] inside {8'h03, 8'h06})) return r;
      a = {q[2], q[3]};
      n = {q[4], q[5]};
      if (q[1] == 8'h06 && !(a[15:12] inside {4'hD, 4'hE})) return q;
      if (q[1] == 8'h03 && n != 16'h0000 && a[15:12] != 4'hF) begin
         if (n > 16'h007B) n = 16'h007B;
         r = {q[0], q[1], 8'(n * 2)};
         for (int i = 0; i < n; i++) begin
            v = reg_val(a + 16'(i));
            r.push_back(v[15:8]);
            r.push_back(v[7:0]);
         end
      end else begin
         r = {q[0], q[1] | 8'h80, (q[1] == 8'h06 && a[15:12] == 4'hD) ? 8'h0A : 8'h02};
      end
      add_crc(r);
      return r;
   endfunction

   always begin
      @(posedge clk);
      if (rd_req === 1'b1) begin
         repeat (lfsr_next() % 3) @(posedge clk);
         #1;
         acc_count++;
         rd_err = (rd_addr[15:12] == 4'hF);
         rd_ack = !rd_err;
         rd_data = reg_val(rd_addr);
         @(posedge clk);
         #1;
         {rd_ack, rd_err} = 2'h0;
         rd_data = ~rd_data;
      end
   end

   always begin
      @(posedge clk);
      if (wr_req === 1'b1) begin
         #1;
         acc_count++;
         wr_seen_addr = wr_addr;
         wr_seen_data = wr_data;
         wr_err_addr = (wr_addr[15:12] == 4'hE);
         wr_err_prot = (wr_addr[15:12] == 4'hD);
         wr_ack = !wr_err_addr && !wr_err_prot;
         @(posedge clk);
         #1;
         {wr_ack, wr_err_addr, wr_err_prot} = 3'h0;
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic transact(input mbslv_bq_t q, input string name);
      mbslv_bq_t e;
      int        n;
      int        acc0;
      e = reply(q);
      acc0 = acc_count;
      mbslv_master_inst.rsp_q.delete();
      foreach (q[i]) mbslv_master_inst.send_byte(q[i]);
      n = 0;
      while (mbslv_master_inst.rsp_q.size() < e.size() && n < 8000) begin
         @(posedge clk);
         n++;
      end
      repeat (GAP + 200) @(posedge clk);
      #1;
      check(16'(mbslv_master_inst.rsp_q.size()), 16'(e.size()), "reply length");
      foreach (e[i]) begin
         if (i < mbslv_master_inst.rsp_q.size())
            check(16'(mbslv_master_inst.rsp_q[i]), 16'(e[i]), "reply byte");
      end
      if (e.size() == 0) check(16'(acc_count - acc0), 16'h0000, "silent access");
      $display("test %s done", name);
   endtask

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (100000) @(posedge clk);
      miscompares++;
      complete_run();
   end

   initial begin
      mbslv_bq_t   q;
      logic [15:0] r;
      repeat (12) @(posedge clk);
      #1;
      nrst = 1'b1;
      q = mkq(8'h01, 8'h06, 16'h0040, 16'h0010);
      check({q[6], q[7]}, 16'h89D2, "write check bytes");
      transact(q, "reference write");
      check(wr_seen_addr, 16'h0040, "write address");
      check(wr_seen_data, 16'h0010, "write data");
      q = mkq(8'h01, 8'h03, 16'h0020, 16'h0010);
      check({q[6], q[7]}, 16'h45CC, "read check bytes");
      transact(q, "reference read");
      transact(mkq(8'h01, 8'h03, 16'h0100, 16'h007D), "clipped read");
      transact(mkq(8'h01, 8'h03, 16'hF000, 16'h0002), "unmapped read");
      transact(mkq(8'h01, 8'h03, 16'h0010, 16'h0000), "empty read");
      transact(mkq(8'h01, 8'h06, 16'hE001, 16'h1234), "unmapped write");
      transact(mkq(8'h01, 8'h06, 16'hD001, 16'h1234), "protected write");
      q = mkq(8'h01, 8'h06, 16'h0041, 16'h5555);
      q[7] = ~q[7];
      transact(q, "bad check");
      q = mkq(8'h01, 8'h03, 16'h0041, 16'h0001);
      q.push_back(8'h00);
      transact(q, "long frame");
      transact(mkq(8'h02, 8'h03, 16'h0000, 16'h0001), "foreign address");
      transact(mkq(8'h01, 8'h10, 16'h0000, 16'h0001), "other function");
      slave_addr = 8'hF0;
      transact(mkq(8'hF0, 8'h06, 16'h0042, 16'hBEEF), "top address");
      slave_addr = 8'hF5;
      transact(mkq(8'hF5, 8'h03, 16'h0000, 16'h0001), "invalid own address");
      slave_addr = 8'h01;
      for (int i = 0; i < 10; i++) begin
         r = lfsr_next();
         mbslv_master_inst.slow = r[1];
         if (r[0]) transact(mkq(8'h01, 8'h03, lfsr_next() & 16'h7FFF,
                                lfsr_next() & 16'h003F), "random read");
         else transact(mkq(8'h01, 8'h06, lfsr_next(), lfsr_next()), "random write");
      end
      complete_run();
   end
endmodule
`default_nettype wire
